// [logic/two_pin_aux_io_port.v]
// two-line auxiliary digital i/o port with pin control register and function priority
// Function
// R01 - each line has a direction bit; 0 input, 1 output; bit0 line0, bit1 line1
// R02 - output level bits 8 and 9 drive lines 0 and 1; 0 low, 1 high
// R03 - misc control beats alarm control, which beats pin control register
// R04 - pin control register clears to zero on any reset
// R05 - pin control is 16-bit read/write register at byte addresses 0x32, 0x33
// R06 - enabled sample ready signal routes to line chosen by select bit, polarity bit
// R07 - unused bits 15:10 and 7:2 ignore writes and read as zero
`timescale 1ns/1ps
`include "aux_pin_port_regs.vh"

module two_pin_aux_io_port (
    input  wire        clk,
    input  wire        reset_n,
    // byte-wide register access from the device register map
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire [7:0]  reg_wdata,
    output wire [7:0]  reg_rdata,
    output wire        reg_hit,
    // misc control data-ready fields and event
    input  wire [2:0]  misc_control,
    input  wire        sample_ready_signal,
    // alarm function claims on each line
    input  wire [1:0]  alarm_control_en,
    input  wire [1:0]  alarm_control_level,
    // pins
    input  wire        aux_pin_zero_in,
    output wire        aux_pin_zero_out,
    output wire        aux_pin_zero_oe,
    input  wire        aux_pin_one_in,
    output wire        aux_pin_one_out,
    output wire        aux_pin_one_oe,
    // state of the pins, as seen by software elsewhere
    output reg  [1:0]  pin_level_ff
);

    // register state and its next value
    reg  [15:0] pin_ctrl_ff;
    reg  [15:0] nxt_pin_ctrl;

    // driver decision of line zero
    reg         zero_oe_sel;
    reg         zero_val_sel;

    // driver decision of line one
    reg         one_oe_sel;
    reg         one_val_sel;

    // which function claims each line, index 0 is line zero
    reg  [1:0]  misc_claim;
    reg  [1:0]  alarm_claim;

    // register-owned direction and level of each line
    wire [1:0]  reg_dir;
    wire [1:0]  reg_lvl;

    // mask of the implemented register bits
    wire [15:0] used_mask;

    // sample ready level after polarity
    wire        srdy_lvl;

    // byte lane selects and write strobes
    wire        hit_lo;
    wire        hit_hi;
    wire        wr_lo;
    wire        wr_hi;

    // true when the byte address selects the given register byte
    function addr_match;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_match = (addr == target);
        end
    endfunction

    // applies a write byte to one lane, keeping only implemented bits
    function [7:0] lane_merge;
        input [7:0] old_byte;
        input [7:0] new_byte;
        input [7:0] used;
        input       we;
        begin
            if (we) begin
                lane_merge = new_byte & used;
            end else begin
                lane_merge = old_byte & used;
            end
        end
    endfunction

    // level shown on the pin for an event under a polarity setting
    function apply_polarity;
        input evt;
        input active_high;
        begin
            if (active_high) begin
                apply_polarity = evt;
            end else begin
                apply_polarity = ~evt;
            end
        end
    endfunction

    // implemented bits: both direction bits and both level bits
    assign used_mask = `PIN_CTRL_USED_MASK; // R07

    // address decode of the two register bytes
    assign hit_lo  = addr_match(reg_addr, `PIN_CTRL_ADDR_LO); // R05
    assign hit_hi  = addr_match(reg_addr, `PIN_CTRL_ADDR_HI); // R05
    assign reg_hit = hit_lo | hit_hi;

    // write strobes per byte lane; the two bytes are written independently
    assign wr_lo = reg_wr & hit_lo; // R05
    assign wr_hi = reg_wr & hit_hi; // R05

    // write path; unused bits are never stored, so they cannot read back
    always @* begin
        nxt_pin_ctrl[7:0]  = lane_merge(pin_ctrl_ff[7:0], reg_wdata,
                                        used_mask[7:0], wr_lo); // R07
        nxt_pin_ctrl[15:8] = lane_merge(pin_ctrl_ff[15:8], reg_wdata,
                                        used_mask[15:8], wr_hi); // R07
    end

    // pin control register, volatile: any reset returns both direction bits to input
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_ctrl_ff <= `PIN_CTRL_RESET; // R04
        end else begin
            pin_ctrl_ff <= nxt_pin_ctrl;
        end
    end

    // read data, zero for unmapped addresses and unused bits
    assign reg_rdata = hit_lo ? pin_ctrl_ff[7:0] :
                       hit_hi ? pin_ctrl_ff[15:8] : 8'h00; // R07

    // register-owned settings of each line
    assign reg_dir = {pin_ctrl_ff[`PIN_DIR1_BIT], pin_ctrl_ff[`PIN_DIR0_BIT]}; // R01
    assign reg_lvl = {pin_ctrl_ff[`PIN_LVL1_BIT], pin_ctrl_ff[`PIN_LVL0_BIT]}; // R02

    // sample ready level with programmed polarity, high pol means active high
    assign srdy_lvl = apply_polarity(sample_ready_signal,
                                     misc_control[`SRDY_POL_BIT]); // R06

    // claims of the misc and alarm functions on each line
    always @* begin
        misc_claim  = 2'h0;
        alarm_claim = alarm_control_en;
        if (misc_control[`SRDY_EN_BIT]) begin
            if (misc_control[`SRDY_SEL_BIT]) begin
                misc_claim[1] = 1'b1; // R06
            end else begin
                misc_claim[0] = 1'b1; // R06
            end
        end
    end

    // line zero: misc beats alarm, alarm beats the pin register
    always @* begin
        if (misc_claim[0]) begin
            zero_oe_sel  = 1'b1; // R03
            zero_val_sel = srdy_lvl; // R06
        end else if (alarm_claim[0]) begin
            zero_oe_sel  = 1'b1; // R03
            zero_val_sel = alarm_control_level[0];
        end else begin
            zero_oe_sel  = reg_dir[0]; // R01
            zero_val_sel = reg_lvl[0]; // R02
        end
    end

    // line one: same fixed order as line zero
    always @* begin
        if (misc_claim[1]) begin
            one_oe_sel  = 1'b1; // R03
            one_val_sel = srdy_lvl; // R06
        end else if (alarm_claim[1]) begin
            one_oe_sel  = 1'b1; // R03
            one_val_sel = alarm_control_level[1];
        end else begin
            one_oe_sel  = reg_dir[1]; // R01
            one_val_sel = reg_lvl[1]; // R02
        end
    end

    // pin drivers; a released pin is left to its pull-up
    assign aux_pin_zero_oe  = zero_oe_sel;
    assign aux_pin_zero_out = zero_val_sel;
    assign aux_pin_one_oe   = one_oe_sel;
    assign aux_pin_one_out  = one_val_sel;

    // registered pin levels
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_level_ff <= 2'h0;
        end else begin
            pin_level_ff <= {aux_pin_one_in, aux_pin_zero_in};
        end
    end

endmodule // two_pin_aux_io_port

// [logic/aux_pin_port_regs.vh]
// register offsets, field positions and reset values for the aux pin port
`ifndef AUX_PIN_PORT_REGS_VH
`define AUX_PIN_PORT_REGS_VH
`define PIN_CTRL_ADDR_LO   8'h32
`define PIN_CTRL_ADDR_HI   8'h33
`define PIN_CTRL_RESET     16'h0000
`define PIN_CTRL_USED_MASK 16'h0303
`define PIN_DIR0_BIT       0
`define PIN_DIR1_BIT       1
`define PIN_LVL0_BIT       8
`define PIN_LVL1_BIT       9
`define SRDY_SEL_BIT       0
`define SRDY_POL_BIT       1
`define SRDY_EN_BIT        2
`endif

// [tb/aux_pin_port_props.sv]
// assertion checker for the two-line aux pin port
`timescale 1ns/1ps
module aux_pin_port_props (input wire clk, reset_n, sample_ready_signal, aux_pin_zero_out,
    aux_pin_zero_oe, input wire [7:0] reg_addr, reg_rdata, input wire [2:0] misc_control,
    input wire [1:0] alarm_control_en, alarm_control_level);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire own = !misc_control[2] && !alarm_control_en[0]; // pin register owns line 0
    a_dir_bit: assert property (own && reg_addr == 8'h32 |-> aux_pin_zero_oe == reg_rdata[0])
        else $error("line 0 direction wrong");
    a_level_bit: assert property (own && aux_pin_zero_oe && reg_addr == 8'h33
        |-> aux_pin_zero_out == reg_rdata[0]) else $error("line 0 level wrong");
    a_alarm_wins: assert property (!misc_control[2] && alarm_control_en[0]
        |-> aux_pin_zero_oe && aux_pin_zero_out == alarm_control_level[0]) else $error("alarm");
    a_ready_line: assert property (misc_control[2] && !misc_control[0]
        |-> aux_pin_zero_out == (sample_ready_signal ~^ misc_control[1])) else $error("ready");
    a_reset_zero: assert property ($rose(reset_n) |-> reg_rdata == 8'h00)
        else $error("register not cleared");
    a_unmapped_zero: assert property (reg_addr[7:1] != 7'h19 |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_unused_zero: assert property (reg_rdata[7:2] == 6'h00) else $error("unused bits");
endmodule // aux_pin_port_props
bind two_pin_aux_io_port aux_pin_port_props aux_pin_port_props_inst (.*);

// [tb/aux_pins_model.sv]
// pull-up circuits hanging on the two aux pins
`timescale 1ns/1ps
module aux_pins_model (input wire [1:0] o, e, output wire [1:0] p);
    assign p = o | ~e; // a released pin floats up to the pull-up level
endmodule // aux_pins_model

// [tb/two_pin_aux_io_port_tb.sv]
// self-checking bench for the two-line aux pin port
`timescale 1ns/1ps
module two_pin_aux_io_port_tb;
    reg        clk = 0, reset_n = 0, reg_wr = 0, sample_ready_signal = 0;
    reg  [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    reg  [2:0] misc_control = 3'h0;
    reg  [1:0] alarm_control_en = 2'h0, alarm_control_level = 2'h0;
    wire [7:0] reg_rdata;
    wire [1:0] pin_level_ff;
    wire       reg_hit, aux_pin_zero_in, aux_pin_zero_out, aux_pin_zero_oe;
    wire       aux_pin_one_in, aux_pin_one_out, aux_pin_one_oe;
    wire [14:0] q = {reg_hit, pin_level_ff, reg_rdata, aux_pin_one_oe, aux_pin_one_in,
                     aux_pin_zero_oe, aux_pin_zero_in};
    integer    n_fail = 0, num_checks = 0, cyc = 0;
    initial forever #10 clk = ~clk; // 50 mhz
    always @(posedge clk) if (++cyc == 500) complete_run(1); // hang guard
    two_pin_aux_io_port two_pin_aux_io_port_inst (.*);
    aux_pins_model aux_pins_model_inst (.o({aux_pin_one_out, aux_pin_zero_out}),
        .e({aux_pin_one_oe, aux_pin_zero_oe}), .p({aux_pin_one_in, aux_pin_zero_in}));
    // apply inputs, let a write land, then compare read byte and pin wires
    task s(input [8:0] c, input [7:0] a, d, input w, input [14:0] x);
        @(posedge clk) #1 {reset_n, misc_control, sample_ready_signal, alarm_control_en,
            alarm_control_level, reg_addr, reg_wdata, reg_wr} = {c, a, d, w};
        @(posedge clk) #1 reg_wr = 0;
        @(posedge clk) #1; // let the registered pin levels catch up
        #1 num_checks = num_checks + 1;
        n_fail = n_fail + (q !== x);
        if (q !== x) $display("unexpected at %0t: got %h want %h", $time, q, x);
    endtask
    // print counts and verdict, then stop
    task complete_run(input late);
        n_fail = n_fail + late;
        $display("%0d checks, %0d mismatches", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin // reset, register access, priority, second reset
        repeat (12) @(posedge clk);
        s(9'h100, 8'h32, 8'hff, 1, 15'h403a);
        s(9'h100, 8'h33, 8'hfe, 1, 15'h602e);
        s(9'h100, 8'h40, 8'hff, 1, 15'h200e);
        s(9'h105, 8'h33, 8'h00, 0, 15'h702f);
        s(9'h1c5, 8'h33, 8'h00, 0, 15'h602e);
        s(9'h1b5, 8'h33, 8'h00, 0, 15'h502b);
        s(9'h000, 8'h32, 8'h00, 0, 15'h4005);
        s(9'h100, 8'h32, 8'h00, 0, 15'h7005);
        $display("pin port test done");
        complete_run(0);
    end
endmodule // two_pin_aux_io_port_tb
